// [verilog/lp_pkg.sv]
// Constants, register map and types for the low-power halt and wake-up block
`default_nettype none

package lp_pkg;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CLK_MODE  = 6'h03;
  localparam logic [5:0] IDX_MISC      = 6'h04;
  localparam logic [5:0] IDX_PIN_WAKE  = 6'h05;
  localparam logic [5:0] IDX_STATUS    = 6'h06;

  // Clock mode fields
  localparam int unsigned CLKMD_XTAL_BIT = 1;
  localparam int unsigned CLKMD_LF_BIT   = 2;
  localparam int unsigned CLKMD_HF_BIT   = 4;
  // Misc control fields
  localparam int unsigned MISC_FAST_BIT  = 5;

  // Reset values
  localparam logic [7:0] CLKMD_RST     = 8'h14;
  localparam logic [7:0] MISC_RST      = 8'h00;
  localparam logic [7:0] PIN_WAKE_RST  = 8'h00;

  // Wake-up lengths in low-frequency oscillator periods
  localparam int unsigned WAKE_NORMAL_LF = 3000;
  localparam int unsigned WAKE_FAST_LF   = 45;
  localparam int unsigned WAKE_CNT_W     = 12;

  // Number of wake-capable pins
  localparam int unsigned PIN_COUNT      = 8;

  // Power states
  typedef enum logic [1:0] {PM_RUN, PM_LIGHT, PM_DEEP, PM_WAKE} pm_state_t;

endpackage

`default_nettype wire

// [verilog/lf_wake_timer.sv]
// Wake-up delay counter stepped by low-frequency oscillator ticks
`default_nettype none

module lf_wake_timer #(
  parameter int unsigned CNT_W  = lp_pkg::WAKE_CNT_W,
  parameter int unsigned NORMAL = lp_pkg::WAKE_NORMAL_LF,
  parameter int unsigned FAST   = lp_pkg::WAKE_FAST_LF
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Control
  input  wire logic start,
  input  wire logic fast,
  input  wire logic tick,
  // Result
  output logic      done
);
  import lp_pkg::*;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } tmr_st_t;

  tmr_st_t          q;
  tmr_st_t          d;
  logic [CNT_W-1:0] limit;

  assign limit = fast ? CNT_W'(FAST) : CNT_W'(NORMAL);
  assign done  = q.done;

  // Count ticks from start, pulse done on the last one
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.cnt  = '0;
    end else if (q.busy && tick) begin
      if (q.cnt + CNT_W'(1) == limit) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// [verilog/lp_halt_wake.sv]
// Halt state control, wake-up source selection and AHB-Lite registers
`default_nettype none

module lp_halt_wake #(
  parameter int unsigned PINS   = lp_pkg::PIN_COUNT,
  parameter int unsigned NORMAL = lp_pkg::WAKE_NORMAL_LF,
  parameter int unsigned FAST   = lp_pkg::WAKE_FAST_LF
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // CPU core
  input  wire logic             halt_deep,
  input  wire logic             halt_light,
  output logic                  resume,
  output logic                  system_clock_en,
  // Fast boot option strap
  input  wire logic             fast_boot_opt,
  // Wake-up sources
  input  wire logic [PINS-1:0]  wake_pin,
  input  wire logic             timer_hit,
  input  wire logic             timer_on_sys_clk,
  input  wire logic             cmp_wake,
  input  wire logic             low_freq_rc_osc,
  // Power controls
  output logic                  high_freq_rc_en,
  output logic                  low_freq_rc_en,
  output logic                  crystal_osc_en,
  output logic                  otp_power_en,
  output logic                  state_hold
);
  import lp_pkg::*;

  typedef struct packed {
    pm_state_t       state;
    logic [7:0]      clkmd;
    logic [7:0]      misc;
    logic [PINS-1:0] dier;
    logic [PINS-1:0] pin_s1;
    logic [PINS-1:0] pin_s2;
    logic [PINS-1:0] pin_prev;
    logic            lf_s1;
    logic            lf_s2;
    logic            lf_prev;
    logic            strap_done;
    logic            fast_boot;
    logic            wake_fast;
    logic            wake_start;
    logic            resume;
    logic [2:0]      cause;
    logic            sys_en;
    logic            hf_en;
    logic            lf_en;
    logic            xt_en;
    logic            otp_en;
    logic            hold;
    logic            ap_valid;
    logic            ap_write;
    logic [5:0]      ap_idx;
    logic [31:0]     hrdata;
  } st_t;

  st_t  q;
  st_t  d;
  logic pin_wake;
  logic tmr_wake;
  logic lf_tick;
  logic fast_sel;
  logic cnt_done;
  logic accept;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Wake event decode

  // Toggle of a synchronised pin with its input enable set
  assign pin_wake = |((q.pin_s2 ^ q.pin_prev) & q.dier);
  // Timer hit counts only when the timer runs from another clock
  assign tmr_wake = timer_hit & ~timer_on_sys_clk;
  assign lf_tick  = q.lf_s2 & ~q.lf_prev;
  // Strap forces fast, else the misc bit chooses
  assign fast_sel = q.fast_boot | q.misc[MISC_FAST_BIT];
  assign accept   = hsel & htrans[1] & hready;
  assign mapped   = haddr[31:8] == 24'h000000;

  lf_wake_timer #(
    .CNT_W  (WAKE_CNT_W),
    .NORMAL (NORMAL),
    .FAST   (FAST)
  ) u_timer (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .start (q.wake_start),
    .fast  (q.wake_fast),
    .tick  (lf_tick),
    .done  (cnt_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d            = q;
    d.pin_s1     = wake_pin;
    d.pin_s2     = q.pin_s1;
    d.pin_prev   = q.pin_s2;
    d.lf_s1      = low_freq_rc_osc;
    d.lf_s2      = q.lf_s1;
    d.lf_prev    = q.lf_s2;
    d.wake_start = 1'b0;
    d.resume     = 1'b0;
    // Strap caught once after reset release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.fast_boot  = fast_boot_opt;
    end
    // Power state machine
    unique case (q.state)
      PM_RUN: begin
        if (halt_deep) begin
          d.state = PM_DEEP;
          d.cause = 3'h0;
        end else if (halt_light) begin
          d.state = PM_LIGHT;
          d.cause = 3'h0;
        end
      end
      PM_LIGHT: begin
        if (pin_wake | tmr_wake | cmp_wake) begin
          d.state      = PM_WAKE;
          d.cause      = {cmp_wake, tmr_wake, pin_wake};
          d.wake_fast  = fast_sel;
          d.wake_start = 1'b1;
        end
      end
      PM_DEEP: begin
        if (pin_wake) begin
          d.state      = PM_WAKE;
          d.cause      = 3'h1;
          d.wake_fast  = fast_sel;
          d.wake_start = 1'b1;
        end
      end
      PM_WAKE: begin
        if (cnt_done) begin
          d.state  = PM_RUN;
          d.resume = 1'b1;
        end
      end
    endcase
    // Register writes, frozen in deep power-down
    if (q.ap_valid && q.ap_write && q.state != PM_DEEP) begin
      unique case (q.ap_idx)
        IDX_CLK_MODE: d.clkmd = hwdata[7:0];
        IDX_MISC:     d.misc  = hwdata[7:0];
        IDX_PIN_WAKE: d.dier  = hwdata[PINS-1:0];
        default:      d.dier  = q.dier;
      endcase
    end
    // Power outputs follow the next state
    d.sys_en = d.state == PM_RUN;
    d.hf_en  = d.state != PM_DEEP && d.clkmd[CLKMD_HF_BIT];
    d.lf_en  = d.state != PM_DEEP && d.clkmd[CLKMD_LF_BIT];
    d.xt_en  = d.state != PM_DEEP && d.clkmd[CLKMD_XTAL_BIT];
    d.otp_en = d.state != PM_DEEP;
    d.hold   = d.state != PM_RUN;
    // Bus address phase and read data
    d.ap_valid = accept & mapped;
    d.ap_write = hwrite;
    d.ap_idx   = haddr[7:2];
    d.hrdata   = 32'h00000000;
    if (accept && !hwrite && mapped) begin
      unique case (haddr[7:2])
        IDX_CLK_MODE: d.hrdata[7:0]      = d.clkmd;
        IDX_MISC:     d.hrdata[7:0]      = d.misc;
        IDX_PIN_WAKE: d.hrdata[PINS-1:0] = d.dier;
        IDX_STATUS:   d.hrdata[5:0]      = {d.fast_boot, d.cause, d.state};
        default:      d.hrdata           = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.state  <= PM_RUN;
      q.clkmd  <= CLKMD_RST;
      q.misc   <= MISC_RST;
      q.dier   <= PINS'(PIN_WAKE_RST);
      q.sys_en <= 1'b1;
      q.otp_en <= 1'b1;
      q.hf_en  <= CLKMD_RST[CLKMD_HF_BIT];
      q.lf_en  <= CLKMD_RST[CLKMD_LF_BIT];
      q.xt_en  <= CLKMD_RST[CLKMD_XTAL_BIT];
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs straight from flops, hreadyout and hresp tied to constants
  assign hrdata          = q.hrdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign resume          = q.resume;
  assign system_clock_en = q.sys_en;
  assign high_freq_rc_en = q.hf_en;
  assign low_freq_rc_en  = q.lf_en;
  assign crystal_osc_en  = q.xt_en;
  assign otp_power_en    = q.otp_en;
  assign state_hold      = q.hold;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Ticks seen by the delay counter during the wake state
  logic [WAKE_CNT_W-1:0] tick_seen;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_seen <= '0;
    end else if (ce) begin
      if (q.state != PM_WAKE || q.wake_start) begin
        tick_seen <= '0;
      end else if (lf_tick) begin
        tick_seen <= tick_seen + WAKE_CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_deep_osc_off;
    q.state == PM_DEEP |-> !high_freq_rc_en && !low_freq_rc_en && !crystal_osc_en;
  endproperty
  a_deep_osc_off: assert property (p_deep_osc_off) else $error("oscillator on in deep halt");

  property p_deep_otp_off;
    ce && q.state == PM_RUN && halt_deep |=> !otp_power_en && q.state == PM_DEEP;
  endproperty
  a_deep_otp_off: assert property (p_deep_otp_off) else $error("program memory on in deep halt");

  property p_deep_regs_hold;
    q.state == PM_DEEP |=> $stable(q.clkmd) && $stable(q.misc) && $stable(q.dier);
  endproperty
  a_deep_regs_hold: assert property (p_deep_regs_hold) else $error("register changed in deep halt");

  property p_deep_pin_only;
    ce && q.state == PM_DEEP && !pin_wake |=> q.state == PM_DEEP;
  endproperty
  a_deep_pin_only: assert property (p_deep_pin_only) else $error("deep halt left without pin toggle");

  property p_light_timer_wakes;
    ce && q.state == PM_LIGHT && (tmr_wake || cmp_wake) |=> q.state == PM_WAKE ##0 q.wake_start;
  endproperty
  a_light_timer_wakes: assert property (p_light_timer_wakes) else $error("light halt missed wake");

  property p_resume_after;
    ce && q.state == PM_WAKE && cnt_done |=> resume && system_clock_en && q.state == PM_RUN;
  endproperty
  a_resume_after: assert property (p_resume_after) else $error("no resume after wake delay");

  property p_normal_len;
    q.state == PM_WAKE && cnt_done && !q.wake_fast |-> tick_seen == WAKE_CNT_W'(NORMAL);
  endproperty
  a_normal_len: assert property (p_normal_len) else $error("normal wake length wrong");

  property p_fast_len;
    q.state == PM_WAKE && cnt_done && q.wake_fast |-> tick_seen == WAKE_CNT_W'(FAST);
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast wake length wrong");

  property p_fast_select;
    ce && q.state != PM_WAKE ##1 q.state == PM_WAKE |-> q.wake_fast == $past(fast_sel);
  endproperty
  a_fast_select: assert property (p_fast_select) else $error("wake length choice wrong");

  property p_light_clocks;
    q.state == PM_LIGHT |-> !system_clock_en && high_freq_rc_en == q.clkmd[CLKMD_HF_BIT];
  endproperty
  a_light_clocks: assert property (p_light_clocks) else $error("light halt clock state wrong");

  property p_system_clock_timer_ignored;
    ce && q.state == PM_LIGHT && timer_on_sys_clk && !pin_wake && !cmp_wake |=> q.state == PM_LIGHT;
  endproperty
  a_system_clock_timer_ignored: assert property (p_system_clock_timer_ignored) else $error("system_clock timer woke");

endmodule

`default_nettype wire

// [dv/lp_partner.sv]
// Far-side model: low-frequency oscillator and wake pins
`default_nettype none

module lp_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Oscillator
  input  wire logic       osc_en,
  output var  logic       osc_out,
  // Pins
  input  wire logic [7:0] pin_flip,
  output var  logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] half_q;

  ////////////////////////////////////////////////////////////////
  // Oscillator of ten clocks a period, idles low while disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q  <= 3'h0;
      osc_out <= 1'b0;
    end else if (!osc_en) begin
      half_q  <= 3'h0;
      osc_out <= 1'b0;
    end else if (half_q == 3'h4) begin
      half_q  <= 3'h0;
      osc_out <= ~osc_out;
    end else begin
      half_q  <= half_q + 3'h1;
    end
  end

  // Input pins toggled on request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pins <= 8'h00;
    else pins <= pins ^ pin_flip;
  end
endmodule

`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the halt and wake-up block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lp_pkg::*;

  logic clk = 0, nrst = 0, ce = 1, hsel = 0, hwrite = 0, hd = 0, hl = 0, fboot = 0;
  logic tmr = 0, tmr_sys = 0, cmp = 0, hrdy, hresp, resume, sck, hf, lf, xt, otp, hold, lfosc;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0]  flip = 8'h00, pins;
  int errors = 0, comparisons = 0, n;

  always #5 clk = ~clk;

  lp_halt_wake #(.PINS(8), .NORMAL(12), .FAST(3)) uut (
    .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .halt_deep(hd), .halt_light(hl), .resume(resume),
    .system_clock_en(sck), .fast_boot_opt(fboot), .wake_pin(pins), .timer_hit(tmr),
    .timer_on_sys_clk(tmr_sys), .cmp_wake(cmp), .low_freq_rc_osc(lfosc),
    .high_freq_rc_en(hf), .low_freq_rc_en(lf), .crystal_osc_en(xt), .otp_power_en(otp),
    .state_hold(hold));

  lp_partner partner (.clk(clk), .nrst(nrst), .osc_en(lf), .osc_out(lfosc), .pin_flip(flip),
    .pins(pins));

  ////////////////////////////////////////////////////////////////
  // AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  // Halt pulse, then settle
  task automatic halt(input logic deep);
    @(posedge clk);
    hd <= deep;
    hl <= !deep;
    @(posedge clk);
    hd <= 1'b0;
    hl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // One-cycle pin flip
  task automatic toggle(input int i);
    @(posedge clk);
    flip <= 8'h01 << i;
    @(posedge clk);
    flip <= 8'h00;
  endtask

  // Wait for resume and check length and restored state
  task automatic wake_chk(input int lo, input int hi, input logic [31:0] st);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (resume !== 1'b1 && n < 400);
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK({sck, hold, otp, lf}, 4'b1011)
    bus(1'b0, IDX_STATUS, 32'h0);
    `CHK(rd & 32'h3f, st)
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200us;
    errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    `CHK({sck, hf, lf, xt, otp, hold}, 6'b111010)
    bus(1'b0, IDX_CLK_MODE, 32'h0);
    `CHK(rd, {24'h0, CLKMD_RST})
    `CHK(hresp, 1'b0)
    bus(1'b0, IDX_MISC, 32'h0);
    `CHK(rd, {24'h0, MISC_RST})
    bus(1'b1, 6'h3f, 32'hff);
    bus(1'b0, 6'h3f, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, IDX_PIN_WAKE, 32'h01);
    bus(1'b0, IDX_PIN_WAKE, 32'h0);
    `CHK(rd, 32'h01)
    // Low-freq and crystal enabled ahead of the deep halt
    bus(1'b1, IDX_CLK_MODE, 32'h16);
    @(posedge clk);
    `CHK({lf, xt}, 2'b11)
    // Deep halt: everything off, only enabled pins wake
    halt(1'b1);
    `CHK({sck, hf, lf, xt, otp, hold}, 6'b000001)
    bus(1'b1, IDX_MISC, 32'h20);
    tmr <= 1'b1;
    cmp <= 1'b1;
    toggle(1);
    repeat (60) @(posedge clk);
    `CHK({hold, sck}, 2'b10)
    tmr <= 1'b0;
    cmp <= 1'b0;
    toggle(0);
    wake_chk(100, 170, 32'h04);
    bus(1'b0, IDX_MISC, 32'h0);
    `CHK(rd, 32'h0)
    // Light halt: timer on system clock ignored, then honoured
    tmr_sys <= 1'b1;
    halt(1'b0);
    `CHK({sck, hf, lf, hold}, 4'b0111)
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK(hold, 1'b1)
    // Timer hit while the clock enable is low must be lost
    tmr_sys <= 1'b0;
    ce      <= 1'b0;
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({hold, sck}, 2'b10)
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
    wake_chk(100, 170, 32'h08);
    // Fast wake from comparator and from deep pin toggle
    bus(1'b1, IDX_MISC, 32'h20);
    halt(1'b0);
    @(posedge clk) cmp <= 1'b1;
    @(posedge clk) cmp <= 1'b0;
    wake_chk(20, 70, 32'h10);
    halt(1'b1);
    toggle(0);
    wake_chk(20, 80, 32'h04);
    // Fast boot strap forces fast wake
    @(posedge clk);
    nrst  <= 1'b0;
    fboot <= 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b1, IDX_PIN_WAKE, 32'h01);
    halt(1'b0);
    toggle(0);
    wake_chk(20, 70, 32'h24);
    print_verdict();
  end
endmodule

`undef CHK
`default_nettype wire
